// ### verilog/rsc_pkg.sv
// Function
// - power-on reset clears all, drives both pins
// - strap configuration changes only at power-on
// - hard reset always asserts soft reset too
// - hard pin open-drain, shared with outside
// - hard reset loads 32-bit configuration word
// - external soft pin seen only when idle
// - soft reset drives soft pin, keeps configuration
// - enabled watchdog expiry starts hard sequence
// - enabled bus-monitor expiry starts hard sequence
// - host command starts internal soft sequence
// - status register records latest reset sources
// - internal power-on held 1024 cycles after release
// - hard pin released 512 cycles after lock
// - soft pin released 515 cycles after lock
// - fourteen strap levels captured at power-on release
package rsc_pkg;

  // sequence lengths, in reference clock cycles
  localparam int POR_STRETCH_CYCLES  = 1024;
  localparam int HARD_RELEASE_CYCLES = 512;
  localparam int SOFT_RELEASE_CYCLES = 515;
  // soft pin lags the hard pin by the difference
  localparam int SOFT_TAIL_CYCLES    = SOFT_RELEASE_CYCLES - HARD_RELEASE_CYCLES;
  // length of a soft-only sequence
  localparam int SOFT_ONLY_CYCLES    = SOFT_RELEASE_CYCLES;
  localparam int CNT_W               = 11;

  // synchroniser depth and post-release blanking of pin inputs
  localparam int SYNC_STAGES = 2;
  localparam int QUIET_W     = 2;
  localparam logic [QUIET_W-1:0] QUIET_CYCLES = 2'h3;

  // strap inputs captured at power-on release
  localparam int CFG_PINS       = 14;
  localparam int CFG_RST_MODE   = 0;
  localparam int CFG_CONF_SLAVE = 1;
  localparam int CFG_SLAVE_SYNC = 2;
  localparam int CFG_SLAVE_WIDE = 3;
  localparam int CFG_CHIP_ID_LO = 4;
  localparam int CFG_CHIP_ID_HI = 7;
  localparam int CFG_BOOT_LO    = 8;
  localparam int CFG_BOOT_HI    = 10;
  localparam int CFG_WDOG_EN    = 11;
  localparam int CFG_CLKMODE_LO = 12;
  localparam int CFG_CLKMODE_HI = 13;
  localparam logic [CFG_PINS-1:0] CFG_RESET_VAL = 14'h0000;

  // hard reset configuration word
  localparam int HCW_W = 32;
  localparam logic [HCW_W-1:0] HCW_RESET_VAL = 32'h0000_0000;

  // reset status bit positions
  localparam int RST_SRC_W   = 6;
  localparam int SRC_POR     = 0;
  localparam int SRC_HARD    = 1;
  localparam int SRC_SOFT    = 2;
  localparam int SRC_WDOG    = 3;
  localparam int SRC_BUSMON  = 4;
  localparam int SRC_HOST    = 5;
  localparam logic [RST_SRC_W-1:0] STATUS_RESET_VAL = 6'h01;

  // one-hot sequencer states
  typedef enum logic [6:0] {
    ST_IDLE        = 7'h01,
    ST_POR_HOLD    = 7'h02,
    ST_POR_STRETCH = 7'h04,
    ST_PLL_WAIT    = 7'h08,
    ST_HARD_DRIVE  = 7'h10,
    ST_SOFT_TAIL   = 7'h20,
    ST_SOFT_DRIVE  = 7'h40
  } rsc_state_t;

endpackage : rsc_pkg

// ### verilog/rsc_cnt_if.sv
`timescale 1ns/1ps
// load/done handshake between sequencer and delay counter
interface rsc_cnt_if #(parameter int W = 11);
  logic         load;   // one-cycle start pulse
  logic [W-1:0] value;  // cycles until done
  logic         done;   // one-cycle expiry pulse

  modport counter (input load, input value, output done);
  modport user    (output load, output value, input done);
endinterface : rsc_cnt_if

// ### verilog/rsc_pin_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser per bit, stage one read only by stage two
module rsc_pin_sync
  import rsc_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic meta;  // first stage, metastability catcher
      // reset to zero: active-low reset pins then read as asserted
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          meta         <= 1'b0;
          sync_out[gi] <= 1'b0;
        end else if (clk_en) begin
          meta         <= async_in[gi];
          sync_out[gi] <= meta;
        end
      end
    end
  endgenerate

endmodule : rsc_pin_sync

// ### verilog/rsc_delay_counter.sv
`timescale 1ns/1ps
// down counter: done pulses value cycles after load
module rsc_delay_counter
  import rsc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic  clock,
  input  wire logic  sys_rst,
  input  wire logic  clk_en,
  rsc_cnt_if.counter cnt
);

  logic [W-1:0] count;    // remaining cycles
  logic         running;  // a delay is in progress
  wire          expire = running & (count == {{(W-1){1'b0}}, 1'b1});

  assign cnt.done = expire & clk_en;

  // a new load restarts the delay, so a stale run never leaks out
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count   <= '0;
      running <= 1'b0;
    end else if (clk_en) begin
      if (cnt.load) begin
        count   <= cnt.value;
        running <= 1'b1;
      end else if (running) begin
        count   <= count - {{(W-1){1'b0}}, 1'b1};
        running <= ~expire;
      end
    end
  end

endmodule : rsc_delay_counter

// ### verilog/rsc_reset_ctrl.sv
`timescale 1ns/1ps
// multi-source reset sequencer; reference clock is the input clock here
// power-on: pin low holds all, release starts the stretch count
// stretch end lifts the pll reset, then lock is awaited
// lock starts the hard count, soft pin follows a short tail later
// hard pin, watchdog and bus monitor join at the lock wait
// soft pin and host command run a soft-only count
// one sequence at a time: sources seen while busy are dropped
// trade-off: no queue, as a busy sequence already resets the cores
// power-on is the exception and restarts from the hold state
// straps and the configuration word are the only stored settings
// status is rewritten whole by each accepted reset
// limitation: counts assume the reference clock equals this clock
// a slower reference would need the count parameters scaled
// all pins are sampled through the synchroniser bank below
module rsc_reset_ctrl
  import rsc_pkg::*;
#(
  parameter int POR_STRETCH  = POR_STRETCH_CYCLES,
  parameter int HARD_RELEASE = HARD_RELEASE_CYCLES,
  parameter int SOFT_TAIL    = SOFT_TAIL_CYCLES,
  parameter int SOFT_ONLY    = SOFT_ONLY_CYCLES
) (
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  input  wire logic                 power_on_reset_n,
  input  wire logic                 hard_reset_n_in,
  output logic                      hard_reset_n_out,
  output logic                      hard_reset_n_oe,
  input  wire logic                 soft_reset_n_in,
  output logic                      soft_reset_n_out,
  output logic                      soft_reset_n_oe,
  input  wire logic                 watchdog_expired,
  input  wire logic                 watchdog_reset_enable,
  input  wire logic                 bus_monitor_expired,
  input  wire logic                 bus_monitor_reset_enable,
  input  wire logic                 host_reset_cmd,
  input  wire logic                 system_pll_lock,
  output logic                      system_pll_reset,
  output logic                      internal_power_on_reset,
  output logic                      hard_domain_reset,
  output logic                      core_reset,
  input  wire logic [CFG_PINS-1:0]  config_pins,
  output logic      [CFG_PINS-1:0]  boot_config,
  output logic      [1:0]           clock_mode_select,
  input  wire logic [HCW_W-1:0]     hard_config_word,
  output logic      [HCW_W-1:0]     hard_config,
  output logic      [RST_SRC_W-1:0] reset_status
);

  // straps, lock and the three reset pins share one synchroniser bank
  // bit 0 power-on, 1 hard pin, 2 soft pin, 3 lock, straps above
  localparam int SYNC_W = CFG_PINS + 4;

  // synchronised pin view
  logic [SYNC_W-1:0]   sync_vec;
  wire                 por_n_s  = sync_vec[0];
  wire                 hard_n_s = sync_vec[1];
  wire                 soft_n_s = sync_vec[2];
  wire                 lock_s   = sync_vec[3];
  wire  [CFG_PINS-1:0] cfg_s    = sync_vec[SYNC_W-1:4];

  // sequencer bookkeeping
  rsc_state_t           state;       // sequencer state
  rsc_state_t           next_state;  // combinational successor
  logic [QUIET_W-1:0]   quiet;       // idle cycles since our own release

  // one shared counter serves every timed state; only one runs at a time
  rsc_cnt_if #(.W(CNT_W)) cnt_bus ();

  // straps need no handshake: they are static while power-on is low
  // every pin passes two flops before the sequencer looks at it
  rsc_pin_sync #(.WIDTH(SYNC_W)) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .async_in ({config_pins, system_pll_lock, soft_reset_n_in,
                hard_reset_n_in, power_on_reset_n}),
    .sync_out (sync_vec)
  );

  // done pulses for one cycle, gated by the clock enable
  rsc_delay_counter #(.W(CNT_W)) u_delay (
    .clock   (clock),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .cnt     (cnt_bus.counter)
  );

  // source decode
  // idle is the only state that takes new non-power-on sources
  wire idle       = (state == ST_IDLE);
  // our own released pins need the sync delay before they read high again
  wire quiet_done = (quiet == QUIET_CYCLES);
  // pins read low when asserted; invert once here
  wire por_ext    = ~por_n_s;
  wire hard_ext   = ~hard_n_s & quiet_done;
  wire soft_ext   = ~soft_n_s & quiet_done;
  // internal expiries share our clock and need no synchroniser
  wire wdog_evt   = watchdog_expired & watchdog_reset_enable;
  wire bmon_evt   = bus_monitor_expired & bus_monitor_reset_enable;
  // requests only leave idle; power-on keeps priority over all of them
  // trade-off: a source arriving mid-sequence is lost, not queued
  // hard sources beat soft ones seen in the same cycle
  wire hard_req   = idle & ~por_ext & (hard_ext | wdog_evt | bmon_evt);
  wire soft_req   = idle & ~por_ext & ~hard_req & (soft_ext | host_reset_cmd);
  // power-on edges drive status clear and strap capture
  wire por_entry  = por_ext & (state != ST_POR_HOLD);
  wire por_exit   = (state == ST_POR_HOLD) & ~por_ext;

  // sources seen this cycle; a hard request masks soft ones
  wire [RST_SRC_W-1:0] src_vec;
  // the power-on bit is written only by the power-on branch below
  assign src_vec[SRC_POR]    = 1'b0;
  assign src_vec[SRC_HARD]   = hard_ext;
  assign src_vec[SRC_WDOG]   = wdog_evt;
  assign src_vec[SRC_BUSMON] = bmon_evt;
  assign src_vec[SRC_SOFT]   = soft_ext & ~hard_req;
  assign src_vec[SRC_HOST]   = host_reset_cmd & ~hard_req;

  // the successor is pure decode of state and sources; the clock enable
  // acts only where state is stored, so a frozen clock holds everything
  // successor state
  always_comb begin
    // hold unless a branch moves on
    next_state = state;
    case (state)
      // waiting for any source
      ST_IDLE: begin
        if (hard_req) begin
          next_state = ST_PLL_WAIT;
        end else if (soft_req) begin
          next_state = ST_SOFT_DRIVE;
        end
      end
      // power-on pin still low
      ST_POR_HOLD: begin
        if (!por_ext) begin
          next_state = ST_POR_STRETCH;
        end
      end
      // internal power-on held after pin release
      ST_POR_STRETCH: begin
        if (cnt_bus.done) begin
          next_state = ST_PLL_WAIT;
        end
      end
      // pll reset lifted, wait for synchronised lock
      ST_PLL_WAIT: begin
        if (lock_s) begin
          next_state = ST_HARD_DRIVE;
        end
      end
      // hard and soft pins both pulled
      ST_HARD_DRIVE: begin
        if (cnt_bus.done) begin
          next_state = ST_SOFT_TAIL;
        end
      end
      // hard released, soft held a few more cycles
      ST_SOFT_TAIL: begin
        if (cnt_bus.done) begin
          next_state = ST_IDLE;
        end
      end
      // soft-only sequence from soft pin or host
      ST_SOFT_DRIVE: begin
        if (cnt_bus.done) begin
          next_state = ST_IDLE;
        end
      end
      // illegal code, recover through idle
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // power-on outranks every sequence in flight
    if (por_ext) begin
      next_state = ST_POR_HOLD;
    end
  end

  // delay loads on entry to a timed state
  // a load only on a state change, so a held state never reloads
  // a power-on restart from any timed state reloads the stretch
  wire entering = (next_state != state);
  assign cnt_bus.load = entering & ((next_state == ST_POR_STRETCH) |
                                    (next_state == ST_HARD_DRIVE) |
                                    (next_state == ST_SOFT_TAIL) |
                                    (next_state == ST_SOFT_DRIVE));
  // the value only matters in the cycle that load is high
  assign cnt_bus.value =
    (next_state == ST_POR_STRETCH) ? CNT_W'(POR_STRETCH) :
    (next_state == ST_HARD_DRIVE)  ? CNT_W'(HARD_RELEASE) :
    (next_state == ST_SOFT_TAIL)   ? CNT_W'(SOFT_TAIL) :
                                     CNT_W'(SOFT_ONLY);

  // pin and reset-domain drive decoded from the successor
  // decoding the successor lets the registered outputs change together
  // with the state, with no extra cycle of lag
  wire next_int_por = (next_state == ST_POR_HOLD) | (next_state == ST_POR_STRETCH);
  wire next_hard    = next_int_por | (next_state == ST_PLL_WAIT) |
                      (next_state == ST_HARD_DRIVE);
  wire next_soft    = next_hard | (next_state == ST_SOFT_TAIL) |
                      (next_state == ST_SOFT_DRIVE);

  // open-drain pins only ever pull low
  // the drive decision lives in the enables; the data bit never changes
  assign hard_reset_n_out = 1'b0;
  assign soft_reset_n_out = 1'b0;

  // state register
  // sys_rst stands for a power-on, so straps are sampled again
  // states change only with the clock enable high
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_POR_HOLD;  // come up as if in power-on reset
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // blanking of pin inputs after our own release
  // without it our own released soft pin, still low through the
  // synchroniser, would read as a fresh external soft reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      quiet <= '0;
    end else if (clk_en) begin
      if (!idle) begin
        quiet <= '0;
      end else if (!quiet_done) begin
        quiet <= quiet + {{(QUIET_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // registered reset outputs
  // every output comes from a flop, so consumers see no decode glitches
  // pll reset shares the internal power-on term: only power-on resets it
  // domain resets track their pins cycle for cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // everything held in reset, both pins pulled
      hard_reset_n_oe         <= 1'b1;
      soft_reset_n_oe         <= 1'b1;
      internal_power_on_reset <= 1'b1;
      system_pll_reset        <= 1'b1;
      hard_domain_reset       <= 1'b1;
      core_reset              <= 1'b1;
    end else if (clk_en) begin
      // follow the successor decode
      hard_reset_n_oe         <= next_hard;
      soft_reset_n_oe         <= next_soft;
      internal_power_on_reset <= next_int_por;
      system_pll_reset        <= next_int_por;
      hard_domain_reset       <= next_hard;
      core_reset              <= next_soft;
    end
  end

  // straps latched once, on power-on release only
  // no other reset path writes here, so mode and identity bits survive
  // hard and soft resets untouched
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      boot_config <= CFG_RESET_VAL;
    end else if (clk_en && por_exit) begin
      boot_config <= cfg_s;
    end
  end

  // clock mode field of the strap copy
  assign clock_mode_select = boot_config[CFG_CLKMODE_HI:CFG_CLKMODE_LO];

  // configuration word taken as the hard pin releases
  // the word must be stable at the end of the hard count; later changes
  // are ignored until the next hard or power-on reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hard_config <= HCW_RESET_VAL;
    end else if (clk_en && (state == ST_HARD_DRIVE) && cnt_bus.done) begin
      hard_config <= hard_config_word;
    end
  end

  // latest-cause record; a new reset replaces the old record whole
  // power-on leaves only its own bit; other sources report together
  // a soft source is not recorded when a hard one wins the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reset_status <= STATUS_RESET_VAL;
    end else if (clk_en) begin
      // power-on entry wipes the older record
      if (por_entry) begin
        reset_status <= STATUS_RESET_VAL;
      // accepted request: record the sources present this cycle, soft ones masked by a hard request
      end else if (hard_req || soft_req) begin
        reset_status <= src_vec;
      end
    end
  end

endmodule : rsc_reset_ctrl

// ### dv/rsc_props.sv
`timescale 1ns/1ps
// port-level checks of the reset sequencer
module rsc_props
  import rsc_pkg::*;
#(
  parameter int POR_STRETCH = POR_STRETCH_CYCLES
) (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input wire logic                 power_on_reset_n,
  input wire logic                 hard_reset_n_out,
  input wire logic                 hard_reset_n_oe,
  input wire logic                 soft_reset_n_out,
  input wire logic                 soft_reset_n_oe,
  input wire logic                 watchdog_expired,
  input wire logic                 watchdog_reset_enable,
  input wire logic                 bus_monitor_expired,
  input wire logic                 bus_monitor_reset_enable,
  input wire logic                 host_reset_cmd,
  input wire logic                 system_pll_reset,
  input wire logic                 internal_power_on_reset,
  input wire logic                 hard_domain_reset,
  input wire logic                 core_reset,
  input wire logic [CFG_PINS-1:0]  boot_config,
  input wire logic [RST_SRC_W-1:0] reset_status
);
  logic [2:0]  idle; // idle cycles, saturating
  logic [10:0] up;   // cycles since power-on pin release
  // idle waits well past the quiet window, so no refusal is mistaken
  always_ff @(posedge clock) begin
    if (sys_rst || soft_reset_n_oe || internal_power_on_reset) idle <= 3'h0;
    else if (idle != 3'h7) idle <= idle + 3'h1;
  end
  // pin release age, absorbs synchroniser lag
  always_ff @(posedge clock) begin
    if (sys_rst || !power_on_reset_n) up <= 11'h000;
    else if (up != 11'h7ff) up <= up + 11'h001;
  end
  wire logic ready = (idle == 3'h7) && power_on_reset_n;
  wire logic wd_go = watchdog_expired && watchdog_reset_enable;
  wire logic bm_go = bus_monitor_expired && bus_monitor_reset_enable;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_both_drive;
    hard_reset_n_oe && soft_reset_n_oe;
  endsequence
  sequence s_soft_tail;
    soft_reset_n_oe [*3] ##1 !soft_reset_n_oe;
  endsequence
  a_hard_has_soft: assert property (hard_reset_n_oe |-> soft_reset_n_oe)
    else $error("hard drive without soft drive");
  a_pins_low: assert property (!hard_reset_n_out && !soft_reset_n_out)
    else $error("open-drain pin drives high");
  a_domains_follow: assert property (hard_domain_reset == hard_reset_n_oe
    && core_reset == soft_reset_n_oe) else $error("domain reset off its pin");
  a_por_clears: assert property (internal_power_on_reset |-> s_both_drive
    ##0 system_pll_reset) else $error("power-on reset incomplete");
  a_por_length: assert property ($fell(internal_power_on_reset) |->
    up >= POR_STRETCH + 1 && up <= POR_STRETCH + 4) else $error("stretch length");
  a_soft_trails: assert property ($fell(hard_reset_n_oe) |-> s_soft_tail)
    else $error("soft release not three cycles later");
  a_cfg_frozen: assert property (!internal_power_on_reset &&
    !$past(internal_power_on_reset) |-> $stable(boot_config)) else $error("straps moved");
  a_wdog_start: assert property (ready && wd_go |=> s_both_drive
    ##0 reset_status[SRC_WDOG]) else $error("watchdog reset missing");
  a_busmon_start: assert property (ready && bm_go |=> s_both_drive
    ##0 reset_status[SRC_BUSMON]) else $error("bus monitor reset missing");
  a_host_soft: assert property (ready && host_reset_cmd && !wd_go && !bm_go |=>
    soft_reset_n_oe && !hard_reset_n_oe && reset_status[SRC_HOST])
    else $error("host reset wrong");
endmodule : rsc_props

bind rsc_reset_ctrl rsc_props #(.POR_STRETCH(POR_STRETCH)) u_props (
  .clock, .sys_rst, .power_on_reset_n, .hard_reset_n_out, .hard_reset_n_oe,
  .soft_reset_n_out, .soft_reset_n_oe, .watchdog_expired, .watchdog_reset_enable,
  .bus_monitor_expired, .bus_monitor_reset_enable, .host_reset_cmd, .system_pll_reset,
  .internal_power_on_reset, .hard_domain_reset, .core_reset, .boot_config, .reset_status);

// ### dv/rsc_board.sv
`timescale 1ns/1ps
// board side: pulled-up reset wires and a lock trailing pll reset
module rsc_board #(
  parameter int LOCK_DLY = 6 // slow lock, cycles
) (
  input  wire logic clock,
  input  wire logic pll_reset,
  input  wire logic hard_out,
  input  wire logic hard_oe,
  input  wire logic soft_out,
  input  wire logic soft_oe,
  input  wire logic hard_pull, // board pulls hard pin
  input  wire logic soft_pull, // board pulls soft pin
  output logic      hard_n,
  output logic      soft_n,
  output logic      lock
);
  int cnt; // cycles since pll reset ended
  // wired-and with pull-up, either party may pull low
  assign hard_n = !((hard_oe && !hard_out) || hard_pull);
  assign soft_n = !((soft_oe && !soft_out) || soft_pull);
  // lock lost with pll reset, back after the delay
  always_ff @(posedge clock) begin
    if (pll_reset) cnt <= 0;
    else if (cnt < LOCK_DLY) cnt <= cnt + 1;
  end
  assign lock = (cnt >= LOCK_DLY);
endmodule : rsc_board

// ### dv/multi_source_reset_controller_tb.sv
`timescale 1ns/1ps
// power-on check first, then the event table, then hand tests for the awkward cases
module multi_source_reset_controller_tb
  import rsc_pkg::*;
;
  typedef struct packed {logic [4:0] src; logic [5:0] stat; logic hard;} rsc_row_t;
  logic clock = 1'b0, sys_rst = 1'b1, por_n = 1'b0, hpull = 1'b0, spull = 1'b0;
  logic ce = 1'b1; // clock enable, dropped once to freeze a sequence
  logic wd = 1'b0, wd_en = 1'b0, bm = 1'b0, bm_en = 1'b0, host = 1'b0;
  logic [CFG_PINS-1:0]  cfg = 14'h2a5c;     // straps for first power-on
  logic [HCW_W-1:0]     hcw = 32'h0000_a5a1;
  logic [HCW_W-1:0]     exp_hcw;            // last word a hard reset took
  logic hard_n, soft_n, lock, h_out, s_out, h_oe, s_oe, pllr, ipor, hdom, core;
  logic [CFG_PINS-1:0]  boot;
  logic [1:0]           cms;
  logic [HCW_W-1:0]     hcfg;
  logic [RST_SRC_W-1:0] stat;
  int                   fails = 0, n_compared = 0, cyc = 0;
  int                   hlen = 0, hlast = 0; // hard drive run outside power-on
  // src bits: host, bus monitor, watchdog, soft pin, hard pin
  rsc_row_t rows [5] = '{'{5'h01, 6'h02, 1'b1}, '{5'h02, 6'h04, 1'b0},
    '{5'h04, 6'h08, 1'b1}, '{5'h08, 6'h10, 1'b1}, '{5'h10, 6'h20, 1'b0}};

  rsc_reset_ctrl #(.POR_STRETCH(8), .HARD_RELEASE(8), .SOFT_TAIL(3), .SOFT_ONLY(8)) dut (
    .clock(clock), .sys_rst(sys_rst), .clk_en(ce), .power_on_reset_n(por_n),
    .hard_reset_n_in(hard_n), .hard_reset_n_out(h_out), .hard_reset_n_oe(h_oe),
    .soft_reset_n_in(soft_n), .soft_reset_n_out(s_out), .soft_reset_n_oe(s_oe),
    .watchdog_expired(wd), .watchdog_reset_enable(wd_en), .bus_monitor_expired(bm),
    .bus_monitor_reset_enable(bm_en), .host_reset_cmd(host), .system_pll_lock(lock),
    .system_pll_reset(pllr), .internal_power_on_reset(ipor), .hard_domain_reset(hdom),
    .core_reset(core), .config_pins(cfg), .boot_config(boot), .clock_mode_select(cms),
    .hard_config_word(hcw), .hard_config(hcfg), .reset_status(stat));
  rsc_board #(.LOCK_DLY(6)) board (.clock(clock), .pll_reset(pllr), .hard_out(h_out),
    .hard_oe(h_oe), .soft_out(s_out), .soft_oe(s_oe), .hard_pull(hpull),
    .soft_pull(spull), .hard_n(hard_n), .soft_n(soft_n), .lock(lock));

  // 20 MHz clock
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // inputs move 2 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  // bounded wait for the soft drive level
  task automatic wait_oe(input logic lvl);
    int k;
    k = 0;
    while (s_oe !== lvl && k < 2000) begin
      step(1);
      k++;
    end
    chk(s_oe, lvl);
  endtask : wait_oe
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test
  // hang guard, far above the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  // length of the last hard drive outside power-on, in clock cycles
  always @(posedge clock) begin
    if (h_oe === 1'b1 && ipor === 1'b0) hlen <= hlen + 1;
    else if (hlen != 0) begin
      hlast <= hlen;
      hlen  <= 0;
    end
  end

  initial begin
    step(3);
    sys_rst = 1'b0;
    chk(stat, 6'h01);
    chk(hcfg, 32'h0);
    chk(ipor, 1'b1);
    step(4);
    por_n = 1'b1;
    wait_oe(0);
    exp_hcw = hcw;
    chk(boot, 14'h2a5c);
    chk(cms, 2'h2);
    chk(hcfg, exp_hcw);
    cfg = 14'h1111; // later hard and soft resets must ignore this; the next power-on takes it
    $display("test power-on done");
    foreach (rows[i]) begin
      hcw = 32'h1234_0000 | 32'(i);
      step(10);
      {host, bm, wd, spull, hpull} = rows[i].src;
      {bm_en, wd_en} = rows[i].src[3:2];
      wait_oe(1);
      {host, bm, wd, spull, hpull} = 5'h00;
      chk(stat, rows[i].stat);
      chk(h_oe, rows[i].hard);
      wait_oe(0);
      if (rows[i].hard) exp_hcw = hcw;
      chk(hcfg, exp_hcw);
      // one cycle to see lock, then the release count of 8
      if (rows[i].hard) chk(hlast, 9);
      chk(boot, 14'h2a5c);
      $display("test row %0d done", i);
    end
    // disabled expiries are refused
    step(10);
    {wd, bm, wd_en, bm_en} = 4'hc;
    step(6);
    chk(s_oe, 1'b0);
    {wd, bm} = 2'h0;
    // soft pin pulled during own reset is not a new source
    host = 1'b1;
    wait_oe(1);
    host = 1'b0;
    spull = 1'b1;
    step(3);
    spull = 1'b0;
    wait_oe(0);
    step(10);
    chk(s_oe, 1'b0);
    chk(stat, 6'h20);
    $display("test refusals done");
    // frozen clock enable holds a soft drive in place
    host = 1'b1;
    wait_oe(1);
    host = 1'b0;
    ce = 1'b0;
    step(20);
    chk(s_oe, 1'b1);
    chk(core, 1'b1);
    ce = 1'b1;
    wait_oe(0);
    step(10);
    $display("test freeze done");
    // power-on preempts a running watchdog reset
    {wd, wd_en} = 2'h3;
    wait_oe(1);
    wd = 1'b0;
    step(2);
    por_n = 1'b0;
    step(4);
    chk(ipor, 1'b1);
    chk(pllr, 1'b1);
    chk(stat, 6'h01);
    por_n = 1'b1;
    wait_oe(0);
    exp_hcw = hcw;
    chk(boot, 14'h1111);
    chk(cms, 2'h1);
    chk(hcfg, exp_hcw);
    // second reset in mid-run
    sys_rst = 1'b1;
    step(1);
    sys_rst = 1'b0;
    chk(boot, 14'h0000);
    wait_oe(0);
    chk(boot, 14'h1111);
    $display("test preempt done");
    finish_test();
  end
endmodule : multi_source_reset_controller_tb
